// ---- dv/ra_chk_sva.sv ----
// port checker for the range and alarm registers
`timescale 1ns/1ns
`default_nettype none
module ra_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic app_rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata_q,
    input wire logic supply_low_alarm,
    input wire logic input_high_alarm,
    input wire logic [3:0] range_select,
    input wire logic internal_reference_off
);
    logic aq, cq;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // which word the last read hit; its data stand now
    always_ff @(posedge clk or posedge rst)
        if (rst) {aq, cq} <= 2'h0;
        else {aq, cq} <= {rd && addr == 8'h20, rd && addr == 8'h14};
    cfg_write_a: assert property (wr && addr == 8'h14 |=> {internal_reference_off, range_select} ==
        {$past(wdata[6]), $past(wdata[3:0])}) else $error("cfg write");
    cfg_read_a: assert property (cq |-> rdata_q == {25'h0, internal_reference_off, 2'h0, range_select})
        else $error("cfg read");
    resv_zero_a: assert property (aq |-> (rdata_q & 32'hFFFF_330E) == 32'h0) else $error("resv");
    any_or_a: assert property (aq |-> rdata_q[0] == |rdata_q[7:4]) else $error("or bit");
    sup_active_a: assert property (aq |-> rdata_q[15] == $past(supply_low_alarm, 2)) else $error("act");
    sup_latch_a: assert property (aq && $past(supply_low_alarm, 2) |-> rdata_q[7]) else $error("latch");
    in_flags_a: assert property (aq && $past(input_high_alarm, 2) |-> rdata_q[10] && rdata_q[4])
        else $error("in flags");
    app_keep_a: assert property (app_rst |=> range_select == $past(range_select) && !internal_reference_off)
        else $error("app rst");
    // main scenarios
    cover property (aq && rdata_q[0]);
    cover property (app_rst);
    cover property (cq && internal_reference_off);
endmodule // ra_chk
bind range_alarm_regs ra_chk u_chk (.*);
`default_nettype wire

// ---- dv/range_alarm_regs_tb.sv ----
// bench for the range and alarm registers
`timescale 1ns/1ns
`default_nettype none
module range_alarm_regs_tb;
    logic clk = 1'h0, rst = 1'h1, app_rst = 1'h0, wr = 1'h0, rd = 1'h0;
    logic irq, internal_reference_off, range_legal, range_unipolar;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata_q;
    logic [3:0] alm = 4'h0, range_select, c, p;
    int mismatches = 0, samples_checked = 0;
    range_alarm_regs dut (.*, .supply_low_alarm(alm[3]), .supply_high_alarm(alm[2]),
        .input_low_alarm(alm[1]), .input_high_alarm(alm[0]));
    task automatic chk(input logic [31:0] g, e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask
    // one strobe cycle; read data land in the cycle after it
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {addr, wdata, wr, rd} <= {a, d, w, !w};
        @(posedge clk);
        {wr, rd} <= 2'h0;
        #1 if (!w) chk(rdata_q, d);
    endtask
    task automatic complete_run;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial forever #4 clk = ~clk;
    // the tests need some hundred and ten cycles
    initial begin
        repeat (2000) @(posedge clk);
        mismatches++;
        complete_run;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        acc(0, 8'h14, 32'h0);
        acc(0, 8'h40, 32'h0);
        // nine codes, reserved bits written as ones
        for (int i = 0; i < 9; i++) begin
            c = i < 5 ? 4'(i) : 4'(i + 3);
            acc(1, 8'h14, 32'hFFFF_FFB0 | {i[0], 6'h0} | c);
            acc(0, 8'h14, {25'h0, i[0], 2'h0, c});
            chk(range_legal, 1'h1);
            chk(range_unipolar, c[3]);
        end
        // a code outside the nine is stored but flagged as not legal
        acc(1, 8'h14, 32'h5);
        acc(0, 8'h14, 32'h5);
        chk(range_legal, 1'h0);
        acc(1, 8'h14, 32'h4B);
        acc(1, 8'h20, 32'hFFFF_FFFF);
        app_rst <= 1'h1;
        @(posedge clk);
        app_rst <= 1'h0;
        acc(0, 8'h14, 32'hB);
        acc(0, 8'h20, 32'h0);
        rst <= 1'h1;
        @(posedge clk);
        rst <= 1'h0;
        acc(0, 8'h14, 32'h0);
        $display("config done");
        // opposite alarm pairs, the first one masked
        for (int j = 0; j < 2; j++) begin
            p = j ? 4'h6 : 4'h9;
            acc(1, 8'h30, {28'h0, {4{j[0]}}});
            alm <= p;
            repeat (3) @(posedge clk);
            #1 chk(irq, j[0]);
            acc(0, 8'h20, {16'h0, p[3:2], 2'h0, p[1:0], 2'h0, p, 4'h1});
            acc(0, 8'h34, {28'h0, p});
            chk(irq, 1'h0);
            @(posedge clk);
            alm <= 4'h0;
            repeat (3) @(posedge clk);
            acc(0, 8'h20, {24'h0, p, 4'h1});
            acc(0, 8'h20, 32'h0);
            $display("alarm pair done");
        end
        complete_run;
    end
endmodule // range_alarm_regs_tb
`default_nettype wire

// ---- include/range_alarm_regs.vh ----
// register offsets, field positions and reset values of the range and alarm registers
`ifndef RANGE_ALARM_REGS_VH
`define RANGE_ALARM_REGS_VH
`define RNG_CFG_ADDR 8'h14
`define ALM_STAT_ADDR 8'h20
`define IRQ_MASK_ADDR 8'h30
`define IRQ_STAT_ADDR 8'h34
`define RNG_SEL_LSB 0
`define RNG_SEL_MSB 3
`define REF_OFF_BIT 6
`define RNG_SEL_RESET 4'h0
`define REF_OFF_RESET 1'b0
`define ALM_SUP_LOW_ACT_BIT 15
`define ALM_SUP_HIGH_ACT_BIT 14
`define ALM_IN_LOW_ACT_BIT 11
`define ALM_IN_HIGH_ACT_BIT 10
`define ALM_SUP_LOW_LAT_BIT 7
`define ALM_SUP_HIGH_LAT_BIT 6
`define ALM_IN_LOW_LAT_BIT 5
`define ALM_IN_HIGH_LAT_BIT 4
`define ALM_ANY_BIT 0
`define IRQ_MASK_RESET 4'h0
`endif

// ---- logic/range_alarm_regs.v ----
// range configuration and alarm status register bank
// Functional notes
// - range register at byte addresses 14h..17h, low byte first
// - range register reserved bits read zero
// - bit 6 disables internal reference, resets to 0
// - bits 3-0 select one of nine ranges
// - range selector resets only on power-on reset; others on both resets
// - alarm status at 20h..23h, all read only
// - alarm status reserved bits read zero
// - bits 15/14 show active low/high supply alarms
// - bits 11/10 show active input low/high alarms (name order taken)
// - bits 7/6 latch tripped low/high supply alarms
// - bits 5/4 latch tripped input low/high alarms
// - bit 0 is OR of the four tripped flags
`timescale 1ns/1ns
`default_nettype none
`include "range_alarm_regs.vh"
module range_alarm_regs (
    input wire clk,
    input wire rst,
    input wire app_rst,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata_q,
    input wire supply_low_alarm,
    input wire supply_high_alarm,
    input wire input_low_alarm,
    input wire input_high_alarm,
    output wire [3:0] range_select,
    output wire internal_reference_off,
    output wire range_legal,
    output wire range_unipolar,
    output wire irq
);
    reg [3:0] range_q;
    reg ref_off_q;
    reg [3:0] act_q;
    reg [3:0] mask_q;
    reg [3:0] irq_stat_q;
    wire [3:0] lat;
    wire [3:0] act_ev;
    wire alarm_rd;
    wire irq_rd;
    wire wr_range;
    wire [31:0] range_word;
    wire [31:0] alarm_word;

    // a bus word hits a register when the aligned base matches
    function hit;
        input [7:0] a;
        input [7:0] base;
        begin
            hit = (a[7:2] == base[7:2]);
        end
    endfunction

    assign wr_range = wr && hit(addr, `RNG_CFG_ADDR);
    assign alarm_rd = rd && hit(addr, `ALM_STAT_ADDR);
    assign irq_rd = rd && hit(addr, `IRQ_STAT_ADDR);

    // range selector: power-on reset only, so app_rst leaves it
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            range_q <= `RNG_SEL_RESET;
        end else if (wr_range) begin
            range_q <= wdata[`RNG_SEL_MSB:`RNG_SEL_LSB];
        end
    end

    // reference disable returns to reset value on either reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_off_q <= `REF_OFF_RESET;
        end else if (app_rst) begin
            ref_off_q <= `REF_OFF_RESET;
        end else if (wr_range) begin
            ref_off_q <= wdata[`REF_OFF_BIT];
        end
    end

    // active flags track comparator levels, registered once
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            act_q <= 4'h0;
        end else begin
            act_q <= {supply_low_alarm, supply_high_alarm, input_low_alarm, input_high_alarm};
        end
    end

    // order: supply low, supply high, input low, input high
    assign act_ev = {supply_low_alarm, supply_high_alarm, input_low_alarm, input_high_alarm};

    // tripped flags; application reset also clears them
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_lat
            sticky_flag u_flag (
                .clk(clk),
                .rst(rst),
                .set(act_ev[i]),
                .clr(alarm_rd | app_rst),
                .flag_q(lat[i])
            );
        end
    endgenerate

    // interrupt status sets on new trips, clears on its own read
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= 4'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & {4{~(irq_rd | app_rst)}}) | (act_ev & ~act_q);
        end
    end

    // mask register enables interrupt sources
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_q <= `IRQ_MASK_RESET;
        end else if (app_rst) begin
            mask_q <= `IRQ_MASK_RESET;
        end else if (wr && hit(addr, `IRQ_MASK_ADDR)) begin
            mask_q <= wdata[3:0];
        end
    end

    assign irq = |(irq_stat_q & mask_q);

    // reserved bits tied zero in both words
    assign range_word = {25'h0000000, ref_off_q, 2'h0, range_q};
    assign alarm_word = {16'h0000, act_q[3], act_q[2], 2'h0, act_q[1], act_q[0], 2'h0,
                         lat[3], lat[2], lat[1], lat[0], 3'h0, |lat};

    // read data one cycle after strobe; unmapped reads give zero
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else if (rd) begin
            if (hit(addr, `RNG_CFG_ADDR)) begin
                rdata_q <= range_word;
            end else if (hit(addr, `ALM_STAT_ADDR)) begin
                rdata_q <= alarm_word;
            end else if (hit(addr, `IRQ_MASK_ADDR)) begin
                rdata_q <= {28'h0000000, mask_q};
            end else if (hit(addr, `IRQ_STAT_ADDR)) begin
                rdata_q <= {28'h0000000, irq_stat_q};
            end else begin
                rdata_q <= 32'h00000000;
            end
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    assign range_select = range_q;
    assign internal_reference_off = ref_off_q;

    range_decode u_dec (
        .code(range_q),
        .legal(range_legal),
        .unipolar(range_unipolar)
    );
endmodule // range_alarm_regs
`default_nettype wire

// ---- logic/range_decode.v ----
// decodes the range code into polarity and legality
`timescale 1ns/1ns
`default_nettype none
module range_decode (
    input wire [3:0] code,
    output wire legal,
    output wire unipolar
);
    // bipolar 0..4, unipolar 8..11
    assign legal = (code <= 4'h4) || (code >= 4'h8 && code <= 4'hB);
    assign unipolar = code[3];
endmodule // range_decode
`default_nettype wire

// ---- logic/sticky_flag.v ----
// one latched alarm flag, set wins over read clear
`timescale 1ns/1ns
`default_nettype none
module sticky_flag (
    input wire clk,
    input wire rst,
    input wire set,
    input wire clr,
    output reg flag_q
);
    // an event in the clearing cycle is kept
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (set) begin
            flag_q <= 1'b1;
        end else if (clr) begin
            flag_q <= 1'b0;
        end
    end
endmodule // sticky_flag
`default_nettype wire
